// *** include/iwd_consts.vh ***
// Constants for the instruction word decoder and its cycle timing
`ifndef IWD_CONSTS_VH
`define IWD_CONSTS_VH

// ========================================
// Word layout
`define IWD_WORD_W 14
`define IWD_GRP_HI 13
`define IWD_GRP_LO 12
`define IWD_OP_HI 13
`define IWD_OP_LO 8
`define IWD_DEST_BIT 7
`define IWD_FILE_HI 6
`define IWD_FILE_LO 0
`define IWD_BITOP_HI 11
`define IWD_BITOP_LO 10
`define IWD_BITIDX_HI 9
`define IWD_BITIDX_LO 7
`define IWD_PTR_BIT 2
`define IWD_MODE_HI 1
`define IWD_MODE_LO 0
`define IWD_LIT_HI 10
`define IWD_LIT_LO 0

// ========================================
// Groups (top two bits of the word)
`define IWD_GRP_BYTE 2'h0
`define IWD_GRP_BIT 2'h1
`define IWD_GRP_LITA 2'h2
`define IWD_GRP_LITB 2'h3
// Reported class
`define IWD_CLS_BYTE 2'h0
`define IWD_CLS_BIT 2'h1
`define IWD_CLS_LIT 2'h2

// ========================================
// Byte-oriented operation codes
`define IWD_OP_MISC 6'h00
`define IWD_OP_DEC_SKIP 6'h0B
`define IWD_OP_INC_SKIP 6'h0F
// Miscellaneous group, low byte
`define IWD_MISC_RETURN 8'h08
`define IWD_MISC_RETINT 8'h09
`define IWD_MISC_CALL_VIA_ACCUMULATOR 8'h0A
`define IWD_MISC_BRW 8'h0B
`define IWD_MISC_IND_LD 5'h02
`define IWD_MISC_IND_ST 5'h03

// Bit-oriented sub-operations
`define IWD_BIT_CLR 2'h0
`define IWD_BIT_SET 2'h1
`define IWD_BIT_SKIPC 2'h2
`define IWD_BIT_SKIPS 2'h3

// Literal and control, top three bits
`define IWD_LIT_CALL 3'h4
`define IWD_LIT_JUMP 3'h5
// Top four / five bits
`define IWD_LIT_RETLIT 4'hD
`define IWD_LIT_RELBR 5'h19

// Indirect access register file addresses
`define IWD_IND0_ADDR 7'h00
`define IWD_IND1_ADDR 7'h01

// ========================================
// Timing
`define IWD_OSC_PER_CYC 4
`define IWD_PH_W 2
`define IWD_PH_LAST 2'h3
`define IWD_PH_READ 2'h1
`define IWD_CYC_W 2
`define IWD_CYC_ONE 2'h1
`define IWD_CYC_TWO 2'h2

`endif

// *** logic/iwd_phase_gen.v ***
// Oscillator phase counter: four oscillator cycles per instruction cycle
`timescale 1ns/100ps
`include "iwd_consts.vh"
module iwd_phase_gen #(
    parameter PH_W = `IWD_PH_W
) (
    clk_sys,
    rst_n,
    phase,
    cyc_end
);
    input wire clk_sys;
    input wire rst_n;
    output wire [PH_W-1:0] phase;
    output wire cyc_end;

    reg [PH_W-1:0] ph_q;
    wire [PH_W-1:0] ph_d;

    assign ph_d = ph_q + {{(PH_W-1){1'b0}}, 1'b1};

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ph_q <= {PH_W{1'b0}};
        end else begin
            ph_q <= ph_d;
        end
    end

    assign phase = ph_q;
    assign cyc_end = (ph_q == `IWD_PH_LAST);
endmodule // iwd_phase_gen

// *** logic/iwd_decoder.v ***
// Instruction word decoder with instruction-cycle timing
// What this block does
// - Takes one 14-bit word holding opcode and all operands per instruction.
// - Classifies each word as byte, bit, or literal-and-control operation.
// - Ordinary instructions finish in exactly one instruction cycle.
// - Direct call and call via accumulator take two cycles.
// - Return, return with literal, return from interrupt take two cycles.
// - Jumps, relative branches, bit skips and count skips take two cycles.
// - Indirect access while pointer addresses program memory adds one cycle.
// - One instruction cycle is four oscillator cycles.
// - File destination instructions read the register before storing.
// - Destination bit zero stores to accumulator, one to file register.
// - File address field selects register 0x00 to 0x7F.
// - Bit index selects one bit of the 8-bit file register.
// - Pointer select chooses one of two pointers and indirect registers.
// - Update mode picks pre/post increment or decrement for the pointer.
// - Don't-care bits are ignored; either value decodes the same.
`timescale 1ns/100ps
`include "iwd_consts.vh"
module iwd_decoder #(
    parameter WORD_W = `IWD_WORD_W
) (
    clk_sys,
    resetn,
    instr_word,
    instr_valid,
    ptr_in_prog_mem,
    instr_take,
    osc_phase,
    cycle_strobe,
    busy,
    instr_class,
    byte_opcode,
    dest_file,
    file_addr,
    bit_index,
    bit_op,
    pointer_sel,
    index_update_mode,
    literal,
    instr_cycles,
    is_call,
    is_return,
    is_branch,
    is_indirect,
    file_rd,
    file_wr,
    acc_wr
);
    input wire clk_sys;
    input wire resetn;
    input wire [WORD_W-1:0] instr_word;
    input wire instr_valid;
    input wire [1:0] ptr_in_prog_mem;
    output wire instr_take;
    output wire [`IWD_PH_W-1:0] osc_phase;
    output wire cycle_strobe;
    output wire busy;
    output wire [1:0] instr_class;
    output wire [5:0] byte_opcode;
    output wire dest_file;
    output wire [6:0] file_addr;
    output wire [2:0] bit_index;
    output wire [1:0] bit_op;
    output wire pointer_sel;
    output wire [1:0] index_update_mode;
    output wire [10:0] literal;
    output wire [`IWD_CYC_W-1:0] instr_cycles;
    output wire is_call;
    output wire is_return;
    output wire is_branch;
    output wire is_indirect;
    output wire file_rd;
    output wire file_wr;
    output wire acc_wr;

    // ========================================
    // Reset release
    reg rst_s1_q;
    reg rst_s2_q;
    wire rst_n;
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    // ========================================
    // Instruction cycle phases
    wire cyc_end;
    iwd_phase_gen #(
        .PH_W(`IWD_PH_W)
    ) u_phase (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .phase(osc_phase),
        .cyc_end(cyc_end)
    );
    assign cycle_strobe = cyc_end;
    // ========================================
    // Field extraction
    wire [1:0] grp;
    wire [5:0] op;
    wire [7:0] low_byte;
    wire [6:0] f_fld;
    wire [1:0] bop;
    assign grp = instr_word[`IWD_GRP_HI:`IWD_GRP_LO];
    assign op = instr_word[`IWD_OP_HI:`IWD_OP_LO];
    assign low_byte = instr_word[7:0];
    assign f_fld = instr_word[`IWD_FILE_HI:`IWD_FILE_LO];
    assign bop = instr_word[`IWD_BITOP_HI:`IWD_BITOP_LO];

    // ========================================
    // Decode of the presented word
    reg [1:0] cls_d;
    reg call_d;
    reg ret_d;
    reg br_d;
    reg ind_d;
    reg ptr_d;
    reg [1:0] mode_d;
    reg rd_d;
    reg wrf_d;
    reg wra_d;
    reg [`IWD_CYC_W-1:0] cyc_d;
    always @* begin
        cls_d = `IWD_CLS_LIT;
        call_d = 1'b0;
        ret_d = 1'b0;
        br_d = 1'b0;
        ind_d = 1'b0;
        ptr_d = 1'b0;
        mode_d = 2'h0;
        rd_d = 1'b0;
        wrf_d = 1'b0;
        wra_d = 1'b0;
        case (grp)
            `IWD_GRP_BYTE: begin
                cls_d = `IWD_CLS_BYTE;
                if (op == `IWD_OP_MISC) begin
                    // Unlisted misc codes decode as no operation
                    if (low_byte == `IWD_MISC_RETURN ||
                        low_byte == `IWD_MISC_RETINT) begin
                        ret_d = 1'b1;
                    end else if (low_byte == `IWD_MISC_CALL_VIA_ACCUMULATOR) begin
                        call_d = 1'b1;
                    end else if (low_byte == `IWD_MISC_BRW) begin
                        br_d = 1'b1;
                    end else if (low_byte[7:3] == `IWD_MISC_IND_LD ||
                                 low_byte[7:3] == `IWD_MISC_IND_ST) begin
                        ind_d = 1'b1;
                        ptr_d = low_byte[`IWD_PTR_BIT];
                        mode_d = low_byte[`IWD_MODE_HI:`IWD_MODE_LO];
                        wra_d = (low_byte[7:3] == `IWD_MISC_IND_LD);
                    end
                end else begin
                    // Read first, even when the result goes back
                    rd_d = 1'b1;
                    wrf_d = instr_word[`IWD_DEST_BIT];
                    wra_d = ~instr_word[`IWD_DEST_BIT];
                    br_d = (op == `IWD_OP_DEC_SKIP) ||
                           (op == `IWD_OP_INC_SKIP);
                    if (f_fld == `IWD_IND0_ADDR ||
                        f_fld == `IWD_IND1_ADDR) begin
                        ind_d = 1'b1;
                        ptr_d = f_fld[0];
                    end
                end
            end
            `IWD_GRP_BIT: begin
                cls_d = `IWD_CLS_BIT;
                rd_d = 1'b1;
                wrf_d = (bop == `IWD_BIT_CLR) || (bop == `IWD_BIT_SET);
                br_d = (bop == `IWD_BIT_SKIPC) ||
                       (bop == `IWD_BIT_SKIPS);
                if (f_fld == `IWD_IND0_ADDR ||
                    f_fld == `IWD_IND1_ADDR) begin
                    ind_d = 1'b1;
                    ptr_d = f_fld[0];
                end
            end
            default: begin
                cls_d = `IWD_CLS_LIT;
                if (instr_word[13:11] == `IWD_LIT_CALL) begin
                    call_d = 1'b1;
                end else if (instr_word[13:11] == `IWD_LIT_JUMP) begin
                    br_d = 1'b1;
                end else if (instr_word[13:10] == `IWD_LIT_RETLIT) begin
                    ret_d = 1'b1;
                    wra_d = 1'b1;
                end else if (instr_word[13:9] == `IWD_LIT_RELBR) begin
                    br_d = 1'b1;
                end
            end
        endcase
        if (call_d || ret_d || br_d) begin
            cyc_d = `IWD_CYC_TWO;
        end else begin
            cyc_d = `IWD_CYC_ONE;
        end
        if (ind_d && ptr_in_prog_mem[ptr_d]) begin
            cyc_d = cyc_d + `IWD_CYC_ONE;
        end
    end

    // ========================================
    // Execution sequencing
    reg busy_q;
    reg first_q;
    reg [`IWD_CYC_W-1:0] left_q;
    reg [WORD_W-1:0] word_q;
    reg [1:0] cls_q;
    reg call_q;
    reg ret_q;
    reg br_q;
    reg ind_q;
    reg ptr_q;
    reg [1:0] mode_q;
    reg rd_q;
    reg wrf_q;
    reg wra_q;
    reg [`IWD_CYC_W-1:0] cyc_q;
    wire last_cyc;
    assign last_cyc = (left_q == {`IWD_CYC_W{1'b0}});
    // Next word accepted only at the boundary after the last cycle
    assign instr_take = cyc_end && last_cyc && instr_valid;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            first_q <= 1'b0;
            left_q <= {`IWD_CYC_W{1'b0}};
            word_q <= {WORD_W{1'b0}};
            cls_q <= `IWD_CLS_BYTE;
            call_q <= 1'b0;
            ret_q <= 1'b0;
            br_q <= 1'b0;
            ind_q <= 1'b0;
            ptr_q <= 1'b0;
            mode_q <= 2'h0;
            rd_q <= 1'b0;
            wrf_q <= 1'b0;
            wra_q <= 1'b0;
            cyc_q <= {`IWD_CYC_W{1'b0}};
        end else if (cyc_end) begin
            first_q <= instr_take;
            if (!last_cyc) begin
                left_q <= left_q - `IWD_CYC_ONE;
            end else if (instr_valid) begin
                busy_q <= 1'b1;
                left_q <= cyc_d - `IWD_CYC_ONE;
                word_q <= instr_word;
                cls_q <= cls_d;
                call_q <= call_d;
                ret_q <= ret_d;
                br_q <= br_d;
                ind_q <= ind_d;
                ptr_q <= ptr_d;
                mode_q <= mode_d;
                rd_q <= rd_d;
                wrf_q <= wrf_d;
                wra_q <= wra_d;
                cyc_q <= cyc_d;
            end else begin
                busy_q <= 1'b0;
                rd_q <= 1'b0;
                wrf_q <= 1'b0;
                wra_q <= 1'b0;
            end
        end
    end

    // ========================================
    // Outputs
    assign busy = busy_q;
    assign instr_class = cls_q;
    assign byte_opcode = word_q[`IWD_OP_HI:`IWD_OP_LO];
    assign dest_file = word_q[`IWD_DEST_BIT];
    assign file_addr = word_q[`IWD_FILE_HI:`IWD_FILE_LO];
    assign bit_index = word_q[`IWD_BITIDX_HI:`IWD_BITIDX_LO];
    assign bit_op = word_q[`IWD_BITOP_HI:`IWD_BITOP_LO];
    assign pointer_sel = ptr_q;
    assign index_update_mode = mode_q;
    assign literal = word_q[`IWD_LIT_HI:`IWD_LIT_LO];
    assign instr_cycles = cyc_q;
    assign is_call = call_q;
    assign is_return = ret_q;
    assign is_branch = br_q;
    assign is_indirect = ind_q;
    // Read in the second phase of the first cycle, store at the final phase
    assign file_rd = busy_q && first_q && rd_q &&
                     (osc_phase == `IWD_PH_READ);
    assign file_wr = busy_q && last_cyc && wrf_q && cyc_end;
    assign acc_wr = busy_q && last_cyc && wra_q && cyc_end;
endmodule // iwd_decoder

// *** testbench/iwd_decoder_checker.sv ***
// Concurrent checks on the instruction decoder top ports
`timescale 1ns/100ps
module iwd_decoder_checker (
    input wire clk_sys,
    input wire resetn,
    input wire [13:0] instr_word,
    input wire instr_valid,
    input wire instr_take,
    input wire [1:0] osc_phase,
    input wire cycle_strobe,
    input wire [1:0] instr_class,
    input wire [5:0] byte_opcode,
    input wire dest_file,
    input wire [6:0] file_addr,
    input wire [2:0] bit_index,
    input wire [1:0] bit_op,
    input wire [1:0] instr_cycles,
    input wire file_rd,
    input wire file_wr,
    input wire acc_wr
);
    // ========================================
    // Timing and field checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    AST_PHASE_RUN: assert property (osc_phase == 2'h1 |=>
        osc_phase == 2'h2 ##1 osc_phase == 2'h3 ##1 osc_phase == 2'h0)
        else $error("phase sequence broken");
    AST_STROBE: assert property (cycle_strobe |-> osc_phase == 2'h3
        ##1 !cycle_strobe [*3] ##1 cycle_strobe)
        else $error("strobe not every fourth clock");
    AST_TAKE_EDGE: assert property (instr_take |->
        cycle_strobe && instr_valid) else $error("take off boundary");
    AST_BYTE_FIELDS: assert property (instr_take |=>
        byte_opcode == $past(instr_word[13:8]) &&
        dest_file == $past(instr_word[7]) &&
        file_addr == $past(instr_word[6:0])) else $error("byte fields");
    AST_BIT_FIELDS: assert property (instr_take |=>
        bit_index == $past(instr_word[9:7]) &&
        bit_op == $past(instr_word[11:10])) else $error("bit fields");
    AST_CLASS: assert property (instr_take |=> instr_class ==
        ($past(instr_word[13]) ? 2'h2 : {1'b0, $past(instr_word[12])}))
        else $error("class wrong");
    AST_ONE_CYCLE: assert property (instr_take ##1 instr_cycles == 2'h1
        ##3 instr_valid |-> instr_take) else $error("one cycle spacing");
    AST_TWO_CYCLE: assert property (instr_take ##1 instr_cycles == 2'h2
        |-> !instr_take [*7]) else $error("two cycle spacing");
    AST_READ_FIRST: assert property (instr_take ##1 (instr_class == 2'h0
        && byte_opcode != 6'h00 && dest_file) |-> ##1 file_rd)
        else $error("no read before write");
    AST_RD_PHASE: assert property (file_rd |-> osc_phase == 2'h1)
        else $error("read off phase one");
    AST_WR_TIME: assert property (instr_take ##1 (instr_class == 2'h0
        && byte_opcode != 6'h00 && instr_cycles == 2'h1)
        |-> ##3 (file_wr || acc_wr)) else $error("store not at phase three");
    AST_DEST: assert property ((file_wr || acc_wr) && instr_class == 2'h0
        && byte_opcode != 6'h00 |-> file_wr == dest_file && acc_wr != dest_file)
        else $error("destination routing");
endmodule // iwd_decoder_checker

bind iwd_decoder iwd_decoder_checker iwd_decoder_checker_inst (
    .clk_sys, .resetn, .instr_word, .instr_valid, .instr_take, .osc_phase,
    .cycle_strobe, .instr_class, .byte_opcode, .dest_file, .file_addr,
    .bit_index, .bit_op, .instr_cycles, .file_rd, .file_wr, .acc_wr
);

// *** testbench/iwd_testbench.sv ***
// Self-checking bench for the instruction decoder
`timescale 1ns/100ps
module testbench;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [13:0] instr_word = 14'h0000;
    logic instr_valid = 1'b1;
    logic [1:0] ptr_in_prog_mem = 2'h0;
    wire instr_take, cycle_strobe, busy, dest_file, pointer_sel;
    wire is_call, is_return, is_branch, is_indirect, file_rd, file_wr, acc_wr;
    wire [1:0] osc_phase, instr_class, bit_op, index_update_mode, instr_cycles;
    wire [5:0] byte_opcode;
    wire [6:0] file_addr;
    wire [2:0] bit_index;
    wire [10:0] literal;
    int mismatches = 0;
    int cmp_count = 0;
    int i;
    // Row: call, return, branch, indirect, pointer-in-program-memory,
    // class, cycles, word
    logic [23:0] rows [0:22] = '{
        24'h0047A5, 24'h00497F, 24'h208B90, 24'h208F10, 24'h408008,
        24'h408009, 24'h80800A, 24'h20800B, 24'h004000, 24'h0153A0,
        24'h01547F, 24'h219905, 24'h219C05, 24'h82A123, 24'h22A800,
        24'h42B455, 24'h22B21F, 24'h148011, 24'h144016, 24'h18801F,
        24'h34CB80, 24'h144701, 24'h004000};

    iwd_decoder iwd_decoder_inst (.clk_sys, .resetn, .instr_word,
        .instr_valid, .ptr_in_prog_mem, .instr_take, .osc_phase,
        .cycle_strobe, .busy, .instr_class, .byte_opcode, .dest_file,
        .file_addr, .bit_index, .bit_op, .pointer_sel, .index_update_mode,
        .literal, .instr_cycles, .is_call, .is_return, .is_branch,
        .is_indirect, .file_rd, .file_wr, .acc_wr);

    always #2.5 clk_sys = ~clk_sys;

    // ========================================
    // Compare and closing tasks
    task automatic chk(input string what, input logic [13:0] exp,
            input logic [13:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check_row(input logic [23:0] r);
        chk("class", r[17:16], instr_class);
        chk("cycles", r[15:14], instr_cycles);
        chk("file_addr", r[6:0], file_addr);
        chk("call", r[23], is_call);
        chk("return", r[22], is_return);
        chk("branch", r[21], is_branch);
        chk("indirect", r[20], is_indirect);
        if (r[17:16] == 2'h0) chk("dest", r[7], dest_file);
        if (r[17:16] == 2'h0) chk("opcode", r[13:8], byte_opcode);
        if (r[17:16] == 2'h1) chk("bit", r[9:7], bit_index);
        if (r[17:16] == 2'h1) chk("bit_op", r[11:10], bit_op);
        if (r[17:16] == 2'h2) chk("literal", r[10:0], literal);
        if (r[13:5] == 9'h0 && r[4]) begin
            chk("ptr", r[2], pointer_sel);
            chk("mode", r[1:0], index_update_mode);
        end
    endtask

    // Presents a word, checks the previous one, then waits for the take
    task automatic send(input logic [23:0] r);
        int n;
        n = 0;
        instr_word <= r[13:0];
        ptr_in_prog_mem <= r[19:18];
        do begin
            @(negedge clk_sys);
            n++;
            if (n == 1 && i > 0) check_row(rows[i-1]);
        end while (instr_take !== 1'b1 && n < 64);
        if (i > 0) chk("spacing", {rows[i-1][15:14], 2'h0}, n);
        @(posedge clk_sys);
    endtask

    // ========================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        for (i = 0; i < 23; i++) send(rows[i]);
        // Word withdrawn: the core must fall idle
        instr_valid <= 1'b0;
        repeat (12) @(negedge clk_sys);
        chk("idle busy", 14'h0, busy);
        chk("idle take", 14'h0, instr_take);
        // Reset on the edge that takes a two-cycle word
        @(posedge clk_sys);
        instr_valid <= 1'b1;
        i = 0;
        send(rows[2]);
        resetn <= 1'b0;
        @(negedge clk_sys);
        chk("reset busy", 14'h0, busy);
        chk("reset phase", 14'h0, osc_phase);
        @(posedge clk_sys);
        resetn <= 1'b1;
        send(rows[2]);
        i = 3;
        send(rows[0]);
        end_sim;
    end

    initial begin
        #50000;
        mismatches++;
        end_sim;
    end
endmodule // testbench
